// [rtl/nipra_top.sv]
// Node identity and PHY register access, APB slave
// Assumes PHY status inputs are synchronous one-cycle pulses or levels
//
// Contract
// RL1 - Node ID is bus field plus node
// RL2 - Valid clears on reset, sets on node
// RL3 - Root flag set when PHY is root
// RL4 - Cable power flag follows PHY report
// RL5 - Node register reserved bits read zero
// RL6 - Bus field writable, updatable, resets ones
// RL7 - Node number loaded after self-ID only
// RL8 - Software avoids transmit run at node 63
// RL9 - Read-complete clears on any request write
// RL10 - Read-complete sets on PHY register return
// RL11 - Capture returned register address
// RL12 - Capture returned register data
// RL13 - Read request self-clears once sent
// RL14 - Write request self-clears once sent
// RL15 - Software never sets both requests
// RL16 - Target address read/write, resets zero
// RL17 - Outgoing data read/write, resets zero
// RL18 - PHY register reserved bits read zero
// RL19 - Each request becomes one PHY request
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module nipra_top import nipra_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phy_bus_reset,
	input wire logic phy_selfid_done,
	input wire logic [5:0] phy_node_number,
	input wire logic phy_is_root,
	input wire logic phy_cable_power_ok,
	input wire logic phy_bus_id_load,
	input wire logic [9:0] phy_bus_id,
	input wire logic phy_reg_return,
	input wire logic [3:0] phy_ret_addr,
	input wire logic [7:0] phy_ret_data,
	input wire logic phy_req_ready,
	output logic phy_req_valid,
	output logic phy_req_write,
	output logic [3:0] phy_req_addr,
	output logic [7:0] phy_req_data,
	output logic [15:0] node_id,
	output logic irq
);
`include "nipra_consts.svh"

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		nipra_apb_st_t apb;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic identity_valid;
		logic root;
		logic cable_power_ok;
		logic [9:0] bus_id_field;
		logic [5:0] physical_node_index;
		logic read_complete;
		logic [3:0] returned_address;
		logic [7:0] returned_data;
		logic read_request;
		logic write_request;
		logic [3:0] target_address;
		logic [7:0] outgoing_data;
		logic [15:0] node_id;
	} nipra_s_t;

	nipra_s_t s_q;
	nipra_s_t s_d;

	logic wr_acc;
	logic rd_acc;
	logic wr_go;
	logic req_sent;
	logic req_start;
	logic [`NIPRA_EV_W-1:0] ev;
	logic [`NIPRA_EV_W-1:0] ev_clr;
	logic en_wr;
	logic [`NIPRA_EV_W-1:0] int_stat;
	logic [`NIPRA_EV_W-1:0] int_en;
	logic [31:0] nid_word;
	logic [31:0] phy_word;

	// One wait state; a write lands on the edge that sees pready
	assign wr_go = psel && penable && pwrite && !s_q.ready;
	assign wr_acc = psel && penable && pwrite && s_q.ready;
	assign rd_acc = psel && penable && !pwrite && !s_q.ready;

	// ------------------------------------------------------------
	// Register words
	// ------------------------------------------------------------
	// RL5 reserved zero
	always_comb begin
		nid_word = 32'h0000_0000;
		nid_word[`NIPRA_NID_VALID] = s_q.identity_valid;
		nid_word[`NIPRA_NID_ROOT] = s_q.root;
		nid_word[`NIPRA_NID_CPS] = s_q.cable_power_ok;
		nid_word[15:6] = s_q.bus_id_field;
		nid_word[5:0] = s_q.physical_node_index;
	end

	// RL18 reserved zero
	always_comb begin
		phy_word = 32'h0000_0000;
		phy_word[`NIPRA_PHY_DONE] = s_q.read_complete;
		phy_word[27:24] = s_q.returned_address;
		phy_word[23:16] = s_q.returned_data;
		phy_word[`NIPRA_PHY_RDREQ] = s_q.read_request;
		phy_word[`NIPRA_PHY_WRREQ] = s_q.write_request;
		phy_word[11:8] = s_q.target_address;
		phy_word[7:0] = s_q.outgoing_data;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.ready = 1'b0;
		s_d.slverr = 1'b0;
		s_d.apb = (psel && !penable) ? NIPRA_APB_ACCESS : NIPRA_APB_IDLE;
		ev_clr = '0;
		en_wr = 1'b0;

		if (wr_go || rd_acc) begin
			s_d.ready = 1'b1;
		end
		// Write error must pulse with pready, not at the commit edge
		if (wr_go && paddr != `NIPRA_OFS_NODE_ID
			&& paddr != `NIPRA_OFS_PHY_ACC
			&& paddr != `NIPRA_OFS_INT_STAT
			&& paddr != `NIPRA_OFS_INT_CLR
			&& paddr != `NIPRA_OFS_INT_EN) begin
			s_d.slverr = 1'b1;
		end

		// Software side of the registers
		if (wr_acc) begin
			if (paddr == `NIPRA_OFS_NODE_ID) begin
				// RL6 bus field writable
				s_d.bus_id_field = pwdata[15:6];
			end else if (paddr == `NIPRA_OFS_PHY_ACC) begin
				// RL16 target address
				s_d.target_address = pwdata[11:8];
				// RL17 outgoing data
				s_d.outgoing_data = pwdata[7:0];
				// RL13 read request set
				if (pwdata[`NIPRA_PHY_RDREQ]) begin
					s_d.read_request = 1'b1;
				end
				// RL14 write request set
				if (pwdata[`NIPRA_PHY_WRREQ]) begin
					s_d.write_request = 1'b1;
				end
				// RL9 done cleared on request
				if (pwdata[`NIPRA_PHY_RDREQ] || pwdata[`NIPRA_PHY_WRREQ]) begin
					s_d.read_complete = 1'b0;
				end
			end else if (paddr == `NIPRA_OFS_INT_CLR) begin
				ev_clr = pwdata[`NIPRA_EV_W-1:0];
			end else if (paddr == `NIPRA_OFS_INT_EN) begin
				en_wr = 1'b1;
			end
		end

		if (rd_acc) begin
			if (paddr == `NIPRA_OFS_NODE_ID) begin
				s_d.rdata = nid_word;
			end else if (paddr == `NIPRA_OFS_PHY_ACC) begin
				s_d.rdata = phy_word;
			end else if (paddr == `NIPRA_OFS_INT_STAT) begin
				s_d.rdata = {29'h0, int_stat};
			end else if (paddr == `NIPRA_OFS_INT_EN) begin
				s_d.rdata = {29'h0, int_en};
			end else begin
				s_d.rdata = 32'h0000_0000;
				s_d.slverr = !(paddr == `NIPRA_OFS_INT_CLR);
			end
		end

		// RL13 read request self-clears
		// RL14 write request self-clears
		if (req_sent) begin
			s_d.read_request = 1'b0;
			s_d.write_request = 1'b0;
		end

		// Hardware side: PHY updates win over software writes
		// RL6 bus field hardware update
		if (phy_bus_id_load) begin
			s_d.bus_id_field = phy_bus_id;
		end
		// RL4 cable power status
		s_d.cable_power_ok = phy_cable_power_ok;
		// RL2 valid clears on bus reset
		if (phy_bus_reset) begin
			s_d.identity_valid = 1'b0;
			// RL3 root sampled during reset
			s_d.root = phy_is_root;
		end else if (phy_selfid_done) begin
			// RL7 node number from PHY
			s_d.physical_node_index = phy_node_number;
			// RL2 valid sets on new node
			s_d.identity_valid = 1'b1;
			s_d.root = phy_is_root;
		end
		// RL10 done set on return
		if (phy_reg_return) begin
			s_d.read_complete = 1'b1;
			// RL11 returned address
			s_d.returned_address = phy_ret_addr;
			// RL12 returned data
			s_d.returned_data = phy_ret_data;
		end
		// RL1 node ID concatenation
		s_d.node_id = {s_d.bus_id_field, s_d.physical_node_index};
	end

	// RL19 one PHY request each
	assign req_start = (s_q.read_request || s_q.write_request) && !req_sent;

	assign ev[`NIPRA_EV_READ_DONE] = phy_reg_return;
	assign ev[`NIPRA_EV_ID_VALID] = phy_selfid_done && !phy_bus_reset;
	assign ev[`NIPRA_EV_BUS_RESET] = phy_bus_reset;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	nipra_phy_req u_req (
		.pclk(pclk),
		.presetn(presetn),
		.start(req_start),
		.start_write(s_q.write_request),
		.start_addr(s_q.target_address),
		.start_data(s_q.outgoing_data),
		.phy_req_ready(phy_req_ready),
		.phy_req_valid(phy_req_valid),
		.phy_req_write(phy_req_write),
		.phy_req_addr(phy_req_addr),
		.phy_req_data(phy_req_data),
		.sent(req_sent)
	);

	nipra_irq u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(ev),
		.clear_in(ev_clr),
		.en_wr(en_wr),
		.en_wdata(pwdata[`NIPRA_EV_W-1:0]),
		.status(int_stat),
		.enable(int_en),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.bus_id_field <= `NIPRA_BUS_ID_RST;
			s_q.physical_node_index <= `NIPRA_NODE_UNSET;
			s_q.node_id <= {`NIPRA_BUS_ID_RST, `NIPRA_NODE_UNSET};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.slverr;
	assign node_id = s_q.node_id;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_bus_reset;
		phy_bus_reset;
	endsequence

	property p_node_id;
		@(posedge pclk) disable iff (!presetn)
		##1 node_id == {s_q.bus_id_field, s_q.physical_node_index};
	endproperty
	a_node_id: assert property (p_node_id) // RL1
		else $error("node id mismatch");

	property p_valid_clear;
		@(posedge pclk) disable iff (!presetn)
		s_bus_reset |=> !s_q.identity_valid;
	endproperty
	a_valid_clear: assert property (p_valid_clear) // RL2
		else $error("valid not cleared");

	property p_root;
		@(posedge pclk) disable iff (!presetn)
		phy_bus_reset |=> s_q.root == $past(phy_is_root);
	endproperty
	a_root: assert property (p_root) // RL3
		else $error("root flag wrong");

	property p_cps;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> s_q.cable_power_ok == $past(phy_cable_power_ok);
	endproperty
	a_cps: assert property (p_cps) // RL4
		else $error("cable power flag wrong");

	property p_rsvd;
		@(posedge pclk) disable iff (!presetn)
		nid_word[29:28] == 2'h0 && nid_word[26:16] == 11'h000
		&& phy_word[30:28] == 3'h0 && phy_word[13:12] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) // RL5 RL18
		else $error("reserved bits not zero");

	property p_node_load;
		@(posedge pclk) disable iff (!presetn)
		phy_selfid_done && !phy_bus_reset |=>
		s_q.physical_node_index == $past(phy_node_number)
		&& s_q.identity_valid;
	endproperty
	a_node_load: assert property (p_node_load) // RL7
		else $error("node number not loaded");

	property p_done_set;
		@(posedge pclk) disable iff (!presetn)
		phy_reg_return |=> s_q.read_complete
		&& s_q.returned_data == $past(phy_ret_data)
		&& s_q.returned_address == $past(phy_ret_addr);
	endproperty
	a_done_set: assert property (p_done_set) // RL10
		else $error("return not captured");

	property p_req_clear;
		@(posedge pclk) disable iff (!presetn)
		req_sent |=> !s_q.read_request && !s_q.write_request;
	endproperty
	a_req_clear: assert property (p_req_clear) // RL13 RL14
		else $error("request bit not cleared");

	property p_one_req;
		@(posedge pclk) disable iff (!presetn)
		phy_req_valid && phy_req_ready |=> !phy_req_valid [*2];
	endproperty
	a_one_req: assert property (p_one_req) // RL19
		else $error("request sent twice");

endmodule : nipra_top

// [rtl/nipra_consts.svh]
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by the package and design modules
`ifndef NIPRA_CONSTS_SVH
`define NIPRA_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define NIPRA_OFS_NODE_ID 12'h0E8
`define NIPRA_OFS_PHY_ACC 12'h0EC
`define NIPRA_OFS_INT_STAT 12'h0F4
`define NIPRA_OFS_INT_CLR 12'h0F8
`define NIPRA_OFS_INT_EN 12'h0FC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NIPRA_NID_VALID 31
`define NIPRA_NID_ROOT 30
`define NIPRA_NID_CPS 27
`define NIPRA_PHY_DONE 31
`define NIPRA_PHY_RDREQ 15
`define NIPRA_PHY_WRREQ 14
`define NIPRA_BUS_ID_RST 10'h3FF
`define NIPRA_NODE_UNSET 6'h3F

// Interrupt status bits
`define NIPRA_EV_READ_DONE 0
`define NIPRA_EV_ID_VALID 1
`define NIPRA_EV_BUS_RESET 2
`define NIPRA_EV_W 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NIPRA_CLK_NS 8
`define NIPRA_REQ_GAP_NS 16
`define NIPRA_REQ_GAP_CYC \
	((`NIPRA_REQ_GAP_NS + `NIPRA_CLK_NS - 1) / `NIPRA_CLK_NS)

`endif

// [rtl/nipra_pkg.sv]
// Types shared by the node identity and PHY access block
// Assumes the constants header is on the include path
package nipra_pkg;
`include "nipra_consts.svh"

	typedef enum logic [1:0] {
		NIPRA_REQ_IDLE = 2'b00,
		NIPRA_REQ_SEND = 2'b01,
		NIPRA_REQ_GAP = 2'b10
	} nipra_req_st_t;

	typedef enum logic [1:0] {
		NIPRA_APB_IDLE = 2'b00,
		NIPRA_APB_ACCESS = 2'b01
	} nipra_apb_st_t;

endpackage : nipra_pkg

// [rtl/nipra_phy_req.sv]
// Sends one PHY register request and holds it until taken
// Assumes the PHY link accepts a request on phy_req_ready
`timescale 1ns/1ps
module nipra_phy_req import nipra_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic start_write,
	input wire logic [3:0] start_addr,
	input wire logic [7:0] start_data,
	input wire logic phy_req_ready,
	output logic phy_req_valid,
	output logic phy_req_write,
	output logic [3:0] phy_req_addr,
	output logic [7:0] phy_req_data,
	output logic sent
);
`include "nipra_consts.svh"

	typedef struct packed {
		nipra_req_st_t st;
		logic valid;
		logic write;
		logic [3:0] addr;
		logic [7:0] data;
		logic sent;
		logic [1:0] gap;
	} nipra_req_s_t;

	nipra_req_s_t s_q;
	nipra_req_s_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.sent = 1'b0;
		case (s_q.st)
			NIPRA_REQ_IDLE: begin
				if (start) begin
					s_d.valid = 1'b1;
					s_d.write = start_write;
					s_d.addr = start_addr;
					// RL17 data zero on reads
					s_d.data = start_write ? start_data : 8'h00;
					s_d.st = NIPRA_REQ_SEND;
				end
			end
			NIPRA_REQ_SEND: begin
				if (phy_req_ready) begin
					s_d.valid = 1'b0;
					s_d.sent = 1'b1;
					s_d.gap = 2'(`NIPRA_REQ_GAP_CYC);
					s_d.st = NIPRA_REQ_GAP;
				end
			end
			NIPRA_REQ_GAP: begin
				// Spacing keeps the sender from re-firing on a stale bit
				if (s_q.gap <= 2'h1) begin
					s_d.st = NIPRA_REQ_IDLE;
				end else begin
					s_d.gap = s_q.gap - 2'h1;
				end
			end
			default: begin
				s_d.st = NIPRA_REQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign phy_req_valid = s_q.valid;
	assign phy_req_write = s_q.write;
	assign phy_req_addr = s_q.addr;
	assign phy_req_data = s_q.data;
	assign sent = s_q.sent;

endmodule : nipra_phy_req

// [rtl/nipra_irq.sv]
// Sticky event status, enable mask and level interrupt
// Assumes event pulses and clear strobes are one cycle wide
`timescale 1ns/1ps
`include "nipra_consts.svh"
module nipra_irq import nipra_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`NIPRA_EV_W-1:0] event_in,
	input wire logic [`NIPRA_EV_W-1:0] clear_in,
	input wire logic en_wr,
	input wire logic [`NIPRA_EV_W-1:0] en_wdata,
	output logic [`NIPRA_EV_W-1:0] status,
	output logic [`NIPRA_EV_W-1:0] enable,
	output logic irq
);

	typedef struct packed {
		logic [`NIPRA_EV_W-1:0] stat;
		logic [`NIPRA_EV_W-1:0] en;
		logic irq;
	} nipra_irq_s_t;

	nipra_irq_s_t s_q;
	nipra_irq_s_t s_d;
	logic [`NIPRA_EV_W-1:0] stat_n;

	// Set wins over a clear in the same cycle
	always_comb begin
		s_d = s_q;
		stat_n = (s_q.stat & ~clear_in) | event_in;
		s_d.stat = stat_n;
		if (en_wr) begin
			s_d.en = en_wdata;
		end
		s_d.irq = |(stat_n & s_d.en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign status = s_q.stat;
	assign enable = s_q.en;
	assign irq = s_q.irq;

endmodule : nipra_irq

// [bench/nipra_phy_model.sv]
// PHY side model: takes register requests, answers reads
// Assumes all PHY-side ports of the block run on pclk
`timescale 1ns/1ps
module nipra_phy_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic phy_req_valid,
	input wire logic phy_req_write,
	input wire logic [3:0] phy_req_addr,
	input wire logic [7:0] phy_req_data,
	output logic phy_req_ready,
	output logic phy_reg_return,
	output logic [3:0] phy_ret_addr,
	output logic [7:0] phy_ret_data,
	output logic phy_bus_reset,
	output logic phy_selfid_done,
	output logic [5:0] phy_node_number,
	output logic phy_is_root,
	output logic phy_cable_power_ok,
	output logic phy_bus_id_load,
	output logic [9:0] phy_bus_id
);
	logic [7:0] regs [16];
	logic [3:0] ret_a, last_addr;
	logic [7:0] last_data;
	logic ret_due, last_write;
	int slow, wait_n, n_req;

	initial begin
		phy_bus_reset = 1'b0;
		phy_selfid_done = 1'b0;
		phy_node_number = 6'h2A;
		phy_is_root = 1'b0;
		phy_cable_power_ok = 1'b0;
		phy_bus_id_load = 1'b0;
		phy_bus_id = 10'h155;
		slow = 0;
		foreach (regs[i]) regs[i] = 8'h00;
	end

	// one request taken, reads answered
	// Idle return lines toggle so stale values never pass
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_req_ready <= 1'b0;
			phy_reg_return <= 1'b0;
			phy_ret_addr <= 4'h5;
			phy_ret_data <= 8'h5A;
			ret_due <= 1'b0;
			wait_n <= 0;
			n_req <= 0;
		end else begin
			phy_reg_return <= 1'b0;
			phy_ret_addr <= ~phy_ret_addr;
			phy_ret_data <= ~phy_ret_data;
			wait_n <= 0;
			if (phy_req_valid && phy_req_ready) begin
				phy_req_ready <= 1'b0;
				n_req <= n_req + 1;
				last_write <= phy_req_write;
				last_addr <= phy_req_addr;
				last_data <= phy_req_data;
				ret_a <= phy_req_addr;
				if (phy_req_write)
					regs[phy_req_addr] <= phy_req_data;
				else
					ret_due <= 1'b1;
			end else if (phy_req_valid) begin
				wait_n <= wait_n + 1;
				if (wait_n >= slow)
					phy_req_ready <= 1'b1;
			end
			if (ret_due) begin
				ret_due <= 1'b0;
				phy_reg_return <= 1'b1;
				phy_ret_addr <= ret_a;
				phy_ret_data <= regs[ret_a];
			end
		end
	end

	task automatic pulse_reset(input logic root);
		@(posedge pclk);
		phy_bus_reset <= 1'b1;
		phy_is_root <= root;
		@(posedge pclk);
		phy_bus_reset <= 1'b0;
		phy_is_root <= ~root;
	endtask : pulse_reset

	task automatic pulse_selfid(input logic root, input logic [5:0] node);
		@(posedge pclk);
		phy_selfid_done <= 1'b1;
		phy_is_root <= root;
		phy_node_number <= node;
		@(posedge pclk);
		phy_selfid_done <= 1'b0;
		phy_is_root <= ~root;
		phy_node_number <= ~node;
	endtask : pulse_selfid

	task automatic load_bus(input logic [9:0] id);
		@(posedge pclk);
		phy_bus_id_load <= 1'b1;
		phy_bus_id <= id;
		@(posedge pclk);
		phy_bus_id_load <= 1'b0;
		phy_bus_id <= ~id;
	endtask : load_bus
endmodule : nipra_phy_model

// [bench/nipra_top_test.sv]
// Self-checking bench for node identity and PHY register access
// Assumes the PHY model drives every PHY-side input
`timescale 1ns/1ps
module nipra_top_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, e;
	logic phy_bus_reset, phy_selfid_done, phy_is_root, phy_cable_power_ok;
	logic phy_bus_id_load, phy_reg_return, phy_req_ready, phy_req_valid;
	logic phy_req_write;
	logic [5:0] phy_node_number;
	logic [9:0] phy_bus_id;
	logic [3:0] phy_ret_addr, phy_req_addr;
	logic [7:0] phy_ret_data, phy_req_data;
	logic [15:0] node_id;
	int errors = 0;
	int n_checks = 0;

	always #4 pclk = ~pclk;

	nipra_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .phy_bus_reset,
		.phy_selfid_done, .phy_node_number, .phy_is_root,
		.phy_cable_power_ok, .phy_bus_id_load, .phy_bus_id,
		.phy_reg_return, .phy_ret_addr, .phy_ret_data, .phy_req_ready,
		.phy_req_valid, .phy_req_write, .phy_req_addr, .phy_req_data,
		.node_id, .irq);

	nipra_phy_model phy (.pclk, .presetn, .phy_req_valid, .phy_req_write,
		.phy_req_addr, .phy_req_data, .phy_req_ready, .phy_reg_return,
		.phy_ret_addr, .phy_ret_data, .phy_bus_reset, .phy_selfid_done,
		.phy_node_number, .phy_is_root, .phy_cable_power_ok,
		.phy_bus_id_load, .phy_bus_id);

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Starts one edge late so no signal is driven twice per step
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("pready", 32'h1, {31'h0, pready});
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask : rd

	task automatic poll(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		n = 0;
		apb(1'b0, a, 32'h0);
		while ((q & m) !== v && n < 30) begin
			apb(1'b0, a, 32'h0);
			n++;
		end
	endtask : poll

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd("node reg", 12'h0E8, 32'h0000_FFFF);
		chk("node err", 32'h0, {31'h0, e});
		rd("phy reg", 12'h0EC, 32'h0);
		chk("node_id", 32'h0000_FFFF, {16'h0, node_id});
	endtask : t_reset

	task automatic t_node();
		phy.phy_cable_power_ok <= 1'b1;
		phy.pulse_reset(1'b1);
		phy.pulse_selfid(1'b1, 6'h05);
		rd("self-id", 12'h0E8, 32'hC800_FFC5);
		wr(12'h0E8, 32'h37FF_557F);
		rd("sw write", 12'h0E8, 32'hC800_5545);
		chk("node_id", 32'h0000_5545, {16'h0, node_id});
		phy.load_bus(10'h2A3);
		rd("bus load", 12'h0E8, 32'hC800_A8C5);
		phy.phy_cable_power_ok <= 1'b0;
		phy.pulse_reset(1'b0);
		rd("bus reset", 12'h0E8, 32'h0000_A8C5);
		phy.pulse_selfid(1'b0, 6'h3F);
		// no transmit run bit here; node 63 only read back
		rd("node 63", 12'h0E8, 32'h8000_A8FF);
	endtask : t_node

	task automatic t_irq();
		rd("status", 12'h0F4, 32'h0000_0006);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(12'h0FC, 32'h0000_0004);
		rd("enable", 12'h0FC, 32'h0000_0004);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(12'h0F8, 32'h0000_0004);
		wr(12'h0F4, 32'h0);
		rd("clear reads 0", 12'h0F8, 32'h0);
		chk("clear rd err", 32'h0, {31'h0, e});
		chk("irq off", 32'h0, {31'h0, irq});
		rd("status left", 12'h0F4, 32'h0000_0002);
		wr(12'h0F8, 32'h0000_0002);
	endtask : t_irq

	task automatic t_phy();
		phy.slow = 0;
		// Request bits are set one at a time, never both
		wr(12'h0EC, 32'h0000_43A5);
		poll(12'h0EC, 32'h0000_4000, 32'h0);
		chk("write sent", 32'h0000_03A5, q);
		chk("req count", 32'h1, phy.n_req);
		chk("req fields", 32'h0000_13A5,
			{phy.last_write, phy.last_addr, phy.last_data});
		wr(12'h0FC, 32'h0000_0001);
		phy.slow = 4;
		wr(12'h0EC, 32'h0000_83FF);
		poll(12'h0EC, 32'h8000_0000, 32'h8000_0000);
		chk("read done", 32'h83A5_03FF, q);
		chk("req count", 32'h2, phy.n_req);
		chk("rd fields", 32'h0000_0300,
			{phy.last_write, phy.last_addr, phy.last_data});
		chk("irq return", 32'h1, {31'h0, irq});
		wr(12'h0F8, 32'h0000_0001);
		rd("status", 12'h0F4, 32'h0);
		chk("irq clear", 32'h0, {31'h0, irq});
		wr(12'h0EC, 32'h0000_4712);
		apb(1'b0, 12'h0EC, 32'h0);
		chk("done cleared", 32'h0, q & 32'h8000_0000);
		poll(12'h0EC, 32'h0000_4000, 32'h0);
		chk("last return", 32'h03A5_0712, q);
		chk("phy reg 7", 32'h0000_0012, {24'h0, phy.regs[7]});
	endtask : t_phy

	task automatic t_unmapped();
		apb(1'b0, 12'h0E4, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
		chk("unmapped wr err", 32'h1, {31'h0, e});
		rd("node kept", 12'h0E8, 32'h8000_A8FF);
	endtask : t_unmapped

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_node();
		t_irq();
		t_phy();
		t_unmapped();
		close_out();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		close_out();
	end
endmodule : nipra_top_test
